// ===== src/msec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module msec_checker
	import msec_pkg::*;
#(
	parameter logic [31:0] CREEP_MIN = msec_pkg::CREEP_MIN_DEF,
	parameter logic [31:0] CREEP_MAX = msec_pkg::CREEP_MAX_DEF,
	parameter logic [31:0] JOG_MIN   = msec_pkg::JOG_MIN_DEF,
	parameter logic [31:0] JOG_MAX   = msec_pkg::JOG_MAX_DEF,
	parameter logic [15:0] COND_MAX  = msec_pkg::COND_MAX_DEF,
	parameter logic [15:0] POS_MAX   = msec_pkg::POS_MAX_DEF,
	parameter logic [31:0] LIN_MAX   = msec_pkg::LIN_MAX_DEF
) (
	input  wire logic                        clk_sys,
	input  wire logic                        nrst,
	input  wire logic                        start,
	input  wire msec_pkg::msec_req_t         req_kind,
	input  wire logic                        hr_req_flag,
	input  wire logic                        restart_ok,
	input  wire logic [msec_pkg::DIST_W-1:0] travel_after_dog,
	input  wire logic [msec_pkg::DIST_W-1:0] decel_dist,
	input  wire logic [msec_pkg::SPD_W-1:0]  creep_speed,
	input  wire logic [msec_pkg::SPD_W-1:0]  jog_speed,
	input  wire logic                        special_start,
	input  wire logic [msec_pkg::NUM_W-1:0]  cond_no,
	input  wire logic [msec_pkg::NUM_W-1:0]  pos_no,
	input  wire logic [msec_pkg::SPD_W-1:0]  cmd_speed,
	input  wire logic                        is_linear,
	input  wire logic [msec_pkg::DIST_W-1:0] lin_dist,
	input  wire logic                        is_arc,
	input  wire logic [msec_pkg::DIST_W-1:0] arc_err,
	input  wire logic [msec_pkg::DIST_W-1:0] arc_allow,
	input  wire logic                        err_reset,
	output logic                             busy,
	output logic                             go_q,
	output msec_pkg::msec_req_t              go_kind_q,
	output logic                             refuse_q,
	output logic                             err_flag_q,
	output msec_pkg::msec_err_t              err_no_q
);
	import msec_pkg::*;

	typedef enum logic [1:0] {MSEC_IDLE, MSEC_CHECK, MSEC_DONE} msec_state_t;

	msec_state_t state_q;
	msec_req_t   kind_q;
	logic        spec_q;
	logic        hr_req_q;
	logic        restart_ok_q;
	logic        travel_bad_q;
	logic        cond_bad_q;
	logic        pos_bad_q;
	logic        speed_none_q;
	logic        lin_q;
	logic        arc_bad_q;
	logic        creep_bad;
	logic        jog_bad;
	logic        lin_bad;
	msec_err_t   err_d;

	// Special-data numbers run from one up to the configured maximum; zero never names an entry.
	function automatic logic num_bad(input logic [NUM_W-1:0] n, input logic [NUM_W-1:0] max_no);
		return (n == '0) || (n > max_no);
	endfunction

	// Range comparisons are shared submodules; both register on every clock edge, the capture edge included.
	// Registering here keeps the wide compares out of the decision path, at one cycle of latency.
	msec_range_chk #(.W(SPD_W)) u_creep (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.value   (creep_speed),
		.lo      (CREEP_MIN),
		.hi      (CREEP_MAX),
		.out_q   (creep_bad)
	);
	msec_range_chk #(.W(SPD_W)) u_jog (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.value   (jog_speed),
		.lo      (JOG_MIN),
		.hi      (JOG_MAX),
		.out_q   (jog_bad)
	);

	assign busy    = (state_q != MSEC_IDLE);
	assign lin_bad = lin_q;

	// Capture request and compare results in the cycle the start is taken.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			kind_q       <= MSEC_REQ_HR_COUNT;
			spec_q       <= 1'b0;
			hr_req_q     <= 1'b0;
			restart_ok_q <= 1'b0;
			travel_bad_q <= 1'b0;
			cond_bad_q   <= 1'b0;
			pos_bad_q    <= 1'b0;
			speed_none_q <= 1'b0;
			lin_q        <= 1'b0;
			arc_bad_q    <= 1'b0;
		end else if (state_q == MSEC_IDLE && start) begin
			kind_q       <= req_kind;
			spec_q       <= special_start;
			hr_req_q     <= hr_req_flag;
			restart_ok_q <= restart_ok;
			travel_bad_q <= (travel_after_dog <= decel_dist);
			cond_bad_q   <= num_bad(cond_no, COND_MAX);
			pos_bad_q    <= num_bad(pos_no, POS_MAX);
			speed_none_q <= (cmd_speed == '0);
			lin_q        <= is_linear && (lin_dist > LIN_MAX);
			arc_bad_q    <= is_arc && (arc_err > arc_allow);
		end
	end

	// Priority picks one error; home-return and special-data checks lead.
	always_comb begin
		err_d = ERR_NONE;
		unique case (kind_q)
			MSEC_REQ_HR_COUNT: begin
				if (travel_bad_q) err_d = ERR_HR_TRAVEL;
				else if (creep_bad) err_d = ERR_HR_CREEP;
			end
			MSEC_REQ_HR_FAST: begin
				if (hr_req_q) err_d = ERR_HR_REQ_ON;
				else if (creep_bad) err_d = ERR_HR_CREEP;
			end
			MSEC_REQ_HR_OTHER: begin
				if (creep_bad) err_d = ERR_HR_CREEP;
			end
			MSEC_REQ_HR_RESTART: begin
				if (!restart_ok_q) err_d = ERR_HR_RESTART;
			end
			MSEC_REQ_JOG: begin
				if (jog_bad) err_d = ERR_JOG_SPEED;
			end
			MSEC_REQ_POS: begin
				if (spec_q && cond_bad_q) err_d = ERR_COND_NO;
				else if (spec_q && pos_bad_q) err_d = ERR_POS_NO;
				else if (speed_none_q) err_d = ERR_NO_SPEED;
				else if (lin_bad) err_d = ERR_LIN_RANGE;
				else if (arc_bad_q) err_d = ERR_ARC;
			end
			default: err_d = ERR_NONE;
		endcase
	end

	// Sequencer: capture, decide, then one cycle of result before idling.
	// The extra result cycle spaces starts three cycles apart so each pulse drops first.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= MSEC_IDLE;
		end else begin
			unique case (state_q)
				MSEC_IDLE:  if (start) state_q <= MSEC_CHECK;
				MSEC_CHECK: state_q <= MSEC_DONE;
				MSEC_DONE:  state_q <= MSEC_IDLE;
			endcase
		end
	end

	// Go or refuse pulse to the motion generator, one cycle long.
	// A latched error turns every start into a refusal until the controller clears it.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			go_q      <= 1'b0;
			refuse_q  <= 1'b0;
			go_kind_q <= MSEC_REQ_HR_COUNT;
		end else begin
			go_q      <= (state_q == MSEC_CHECK) && (err_d == ERR_NONE) && !err_flag_q;
			refuse_q  <= (state_q == MSEC_CHECK) && ((err_d != ERR_NONE) || err_flag_q);
			go_kind_q <= kind_q;
		end
	end

	// Error latch; a new error in the reset cycle wins so it is never lost.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			err_flag_q <= 1'b0;
			err_no_q   <= ERR_NONE;
		end else if (state_q == MSEC_CHECK && err_d != ERR_NONE) begin
			err_flag_q <= 1'b1;
			err_no_q   <= err_d;
		end else if (err_reset) begin
			err_flag_q <= 1'b0;
			err_no_q   <= ERR_NONE;
		end
	end

	// Each analysis check reports its own number and keeps the move from starting.
	a_err_latch_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		err_flag_q && !err_reset && state_q != MSEC_CHECK |=> err_flag_q && $stable(err_no_q))
		else $error("error cleared without reset");
	a_err_zero_when_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(err_no_q == ERR_NONE) == !err_flag_q)
		else $error("error number disagrees with flag");
	a_travel_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_COUNT && travel_bad_q
		|=> refuse_q && !go_q && err_no_q == ERR_HR_TRAVEL)
		else $error("travel error not reported");
	a_hr_req_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_FAST && hr_req_q
		|=> !go_q && err_no_q == ERR_HR_REQ_ON)
		else $error("request-on error not reported");
	a_creep_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_OTHER && creep_bad
		|=> !go_q && err_no_q == ERR_HR_CREEP)
		else $error("creep error not reported");
	a_restart_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_RESTART && !restart_ok_q
		|=> !go_q && err_no_q == ERR_HR_RESTART)
		else $error("restart error not reported");
	a_jog_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && !busy && req_kind == MSEC_REQ_JOG && (jog_speed > JOG_MAX)
		|-> ##2 !go_q ##0 err_no_q == ERR_JOG_SPEED)
		else $error("jog speed error not reported");
	a_cond_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_POS && spec_q && cond_bad_q
		|=> !go_q && err_no_q == ERR_COND_NO)
		else $error("condition number error not reported");
	a_speed_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && !busy && req_kind == MSEC_REQ_POS && !special_start && cmd_speed == '0
		|-> ##2 !go_q && err_no_q == ERR_NO_SPEED)
		else $error("missing speed not reported");
	a_arc_go_block: assert property (@(posedge clk_sys) disable iff (!nrst)
		go_q && go_kind_q == MSEC_REQ_POS |-> !$past(arc_bad_q))
		else $error("arc move started despite mismatch");
	// Later analysis checks only speak once every earlier check on the same start has passed.
	a_pos_no_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_POS && spec_q && !cond_bad_q && pos_bad_q
		|=> refuse_q && !go_q && err_no_q == ERR_POS_NO)
		else $error("positioning number error not reported");
	a_lin_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_POS && !spec_q && !speed_none_q && lin_q
		|=> refuse_q && !go_q && err_no_q == ERR_LIN_RANGE)
		else $error("linear travel error not reported");
	a_arc_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_POS && !spec_q && !speed_none_q
		&& !lin_q && arc_bad_q |=> refuse_q && !go_q && err_no_q == ERR_ARC)
		else $error("arc error not reported");
	a_creep_fast_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_FAST && !hr_req_q && creep_bad
		|=> refuse_q && !go_q && err_no_q == ERR_HR_CREEP)
		else $error("fast creep error not reported");
	a_restart_go: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_HR_RESTART && restart_ok_q && !err_flag_q
		|=> go_q && !refuse_q)
		else $error("permitted restart not started");
	a_jog_go: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_q == MSEC_CHECK && kind_q == MSEC_REQ_JOG && !jog_bad && !err_flag_q
		|=> go_q && go_kind_q == MSEC_REQ_JOG)
		else $error("valid jog not started");

	// A latched error blocks every start, and only an axis error reset clears it.
	a_latched_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		err_flag_q && state_q == MSEC_CHECK
		|=> refuse_q && !go_q)
		else $error("start accepted while an error is latched");
	a_clear_on_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
		err_reset && state_q != MSEC_CHECK
		|=> !err_flag_q && err_no_q == ERR_NONE)
		else $error("axis error reset did not clear the error");
	a_go_clean: assert property (@(posedge clk_sys) disable iff (!nrst)
		go_q
		|-> !err_flag_q && err_no_q == ERR_NONE)
		else $error("motion started with an error shown");

	// Handshake shape: two busy cycles, one answer pulse, and starts while busy are dropped.
	a_busy_span: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && !busy
		|=> busy ##1 busy ##1 !busy)
		else $error("busy span not two cycles");
	a_answer_time: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && !busy
		|-> ##2 (go_q || refuse_q))
		else $error("no answer two cycles after start");
	a_pulse_one_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
		go_q || refuse_q
		|=> !go_q && !refuse_q)
		else $error("answer pulse longer than one cycle");
	a_go_refuse_excl: assert property (@(posedge clk_sys) disable iff (!nrst)
		go_q
		|-> !refuse_q)
		else $error("go and refuse raised together");
	a_go_kind_match: assert property (@(posedge clk_sys) disable iff (!nrst)
		go_q
		|-> go_kind_q == $past(kind_q))
		else $error("go kind differs from checked request");
	a_busy_ignore: assert property (@(posedge clk_sys) disable iff (!nrst)
		busy && start
		|=> $stable(kind_q))
		else $error("start taken while busy");
endmodule // msec_checker
`default_nettype wire

// ===== src/msec_pkg.sv
package msec_pkg;

	// Error numbers are held as three decimal digits in BCD form.
	localparam int ERR_W = 12;
	typedef logic [ERR_W-1:0] msec_err_t;

	localparam msec_err_t ERR_NONE       = 12'h000;
	localparam msec_err_t ERR_HR_TRAVEL  = 12'h206;
	localparam msec_err_t ERR_HR_REQ_ON  = 12'h207;
	localparam msec_err_t ERR_HR_CREEP   = 12'h208;
	localparam msec_err_t ERR_HR_RESTART = 12'h209;
	localparam msec_err_t ERR_JOG_SPEED  = 12'h300;
	localparam msec_err_t ERR_COND_NO    = 12'h500;
	localparam msec_err_t ERR_POS_NO     = 12'h502;
	localparam msec_err_t ERR_NO_SPEED   = 12'h503;
	localparam msec_err_t ERR_LIN_RANGE  = 12'h504;
	localparam msec_err_t ERR_ARC        = 12'h506;

	// Kinds of start request.
	typedef enum logic [2:0] {
		MSEC_REQ_HR_COUNT,
		MSEC_REQ_HR_FAST,
		MSEC_REQ_HR_OTHER,
		MSEC_REQ_HR_RESTART,
		MSEC_REQ_JOG,
		MSEC_REQ_POS
	} msec_req_t;

	// Default value limits.
	localparam int SPD_W        = 32;
	localparam int DIST_W       = 32;
	localparam int NUM_W        = 16;
	localparam logic [31:0] CREEP_MIN_DEF = 32'h0000_0001;
	localparam logic [31:0] CREEP_MAX_DEF = 32'h000F_4240;
	localparam logic [31:0] JOG_MIN_DEF   = 32'h0000_0001;
	localparam logic [31:0] JOG_MAX_DEF   = 32'h000F_4240;
	localparam logic [15:0] COND_MAX_DEF  = 16'h000A;
	localparam logic [15:0] POS_MAX_DEF   = 16'h0258;
	localparam logic [31:0] LIN_MAX_DEF   = 32'h3FFF_FFFF;

endpackage

// ===== src/msec_range_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Inclusive range test, registered so the result lines up with the latched request.
module msec_range_chk #(
	parameter int W = 32
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] lo,
	input  wire logic [W-1:0] hi,
	output logic              out_q
);
	// High when value lies outside lo..hi.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			out_q <= 1'b0;
		end else begin
			out_q <= (value < lo) || (value > hi);
		end
	end
endmodule // msec_range_chk
`default_nettype wire

// ===== testbench/msec_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module msec_cpu_model (
	input  wire logic                clk_sys,
	output var logic                 start,
	output var msec_pkg::msec_req_t  req_kind,
	output var logic                 hr_req_flag,
	output var logic                 restart_ok,
	output var logic [31:0]          travel_after_dog,
	output var logic [31:0]          decel_dist,
	output var logic [31:0]          creep_speed,
	output var logic [31:0]          jog_speed,
	output var logic                 special_start,
	output var logic [15:0]          cond_no,
	output var logic [15:0]          pos_no,
	output var logic [31:0]          cmd_speed,
	output var logic                 is_linear,
	output var logic [31:0]          lin_dist,
	output var logic                 is_arc,
	output var logic [31:0]          arc_err,
	output var logic [31:0]          arc_allow,
	output var logic                 err_reset
);
	import msec_pkg::*;

	// Legal request fields; travel beyond the dog exceeds the deceleration distance.
	initial begin
		start = 1'b0;
		req_kind = MSEC_REQ_HR_COUNT;
		{hr_req_flag, special_start, is_linear, is_arc, err_reset} = 5'h00;
		restart_ok = 1'b1;
		travel_after_dog = 32'h0000_0064;
		decel_dist = 32'h0000_0032;
		{creep_speed, jog_speed, cmd_speed} = {3{32'h0000_000A}};
		{cond_no, pos_no} = {16'h0001, 16'h0001};
		{lin_dist, arc_err, arc_allow} = {32'h0, 32'h0, 32'h0000_0005};
	end

	// Start is raised after a falling edge and held across the taking edge only.
	task automatic issue(input msec_req_t k);
		@(negedge clk_sys);
		req_kind = k;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
	endtask

	// Axis error reset is one full cycle wide.
	task automatic err_clear();
		@(negedge clk_sys);
		err_reset = 1'b1;
		@(negedge clk_sys);
		err_reset = 1'b0;
	endtask
endmodule // msec_cpu_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import msec_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic start, hr_req_flag, restart_ok, special_start, is_linear, is_arc, err_reset;
	logic busy, go_q, refuse_q, err_flag_q;
	logic [31:0] travel_after_dog, decel_dist, creep_speed, jog_speed, cmd_speed;
	logic [31:0] lin_dist, arc_err, arc_allow;
	logic [15:0] cond_no, pos_no;
	msec_req_t req_kind, go_kind_q;
	msec_err_t err_no_q;
	int n_fail = 0;
	int comparisons = 0;

	// Clock at 200 MHz.
	always #2.5 clk_sys = ~clk_sys;

	msec_cpu_model u_cpu (.clk_sys(clk_sys), .start(start), .req_kind(req_kind),
		.hr_req_flag(hr_req_flag), .restart_ok(restart_ok),
		.travel_after_dog(travel_after_dog), .decel_dist(decel_dist),
		.creep_speed(creep_speed), .jog_speed(jog_speed), .special_start(special_start),
		.cond_no(cond_no), .pos_no(pos_no), .cmd_speed(cmd_speed), .is_linear(is_linear),
		.lin_dist(lin_dist), .is_arc(is_arc), .arc_err(arc_err), .arc_allow(arc_allow),
		.err_reset(err_reset));
	msec_checker u_msec_checker (.clk_sys(clk_sys), .nrst(nrst), .start(start),
		.req_kind(req_kind), .hr_req_flag(hr_req_flag), .restart_ok(restart_ok),
		.travel_after_dog(travel_after_dog), .decel_dist(decel_dist),
		.creep_speed(creep_speed), .jog_speed(jog_speed), .special_start(special_start),
		.cond_no(cond_no), .pos_no(pos_no), .cmd_speed(cmd_speed), .is_linear(is_linear),
		.lin_dist(lin_dist), .is_arc(is_arc), .arc_err(arc_err), .arc_allow(arc_allow),
		.err_reset(err_reset), .busy(busy), .go_q(go_q), .go_kind_q(go_kind_q),
		.refuse_q(refuse_q), .err_flag_q(err_flag_q), .err_no_q(err_no_q));

	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One start, judged at the falling edge inside the one-cycle answer pulse.
	task automatic run(input msec_req_t k, input logic ok, input msec_err_t e, input logic clr);
		u_cpu.issue(k);
		@(negedge clk_sys);
		chk("busy", {11'h0, busy}, 12'h001);
		chk("go", {11'h0, go_q}, {11'h0, ok});
		chk("refuse", {11'h0, refuse_q}, {11'h0, !ok});
		chk("err_no", err_no_q, e);
		if (ok) chk("kind", {9'h0, go_kind_q}, {9'h0, k});
		if (clr) begin
			u_cpu.err_clear();
			chk("cleared flag", {11'h0, err_flag_q}, 12'h000);
			chk("cleared number", err_no_q, ERR_NONE);
		end
	endtask

	task automatic t_hr();
		u_cpu.travel_after_dog = 32'h0000_0032;
		run(MSEC_REQ_HR_COUNT, 1'b0, ERR_HR_TRAVEL, 1'b1);
		u_cpu.travel_after_dog = 32'h0000_0033;
		run(MSEC_REQ_HR_COUNT, 1'b1, ERR_NONE, 1'b0);
		{u_cpu.hr_req_flag, u_cpu.creep_speed} = {1'b1, 32'h0};
		run(MSEC_REQ_HR_FAST, 1'b0, ERR_HR_REQ_ON, 1'b1);
		u_cpu.hr_req_flag = 1'b0;
		run(MSEC_REQ_HR_FAST, 1'b0, ERR_HR_CREEP, 1'b1);
		u_cpu.creep_speed = CREEP_MAX_DEF + 32'h1;
		run(MSEC_REQ_HR_OTHER, 1'b0, ERR_HR_CREEP, 1'b1);
		{u_cpu.creep_speed, u_cpu.restart_ok} = {32'h0000_000A, 1'b0};
		run(MSEC_REQ_HR_RESTART, 1'b0, ERR_HR_RESTART, 1'b1);
		u_cpu.restart_ok = 1'b1;
		run(MSEC_REQ_HR_RESTART, 1'b1, ERR_NONE, 1'b0);
		$display("test hr done");
	endtask

	task automatic t_jog();
		u_cpu.jog_speed = JOG_MAX_DEF + 32'h1;
		run(MSEC_REQ_JOG, 1'b0, ERR_JOG_SPEED, 1'b0);
		u_cpu.jog_speed = JOG_MAX_DEF;
		run(MSEC_REQ_JOG, 1'b0, ERR_JOG_SPEED, 1'b1);
		run(MSEC_REQ_JOG, 1'b1, ERR_NONE, 1'b0);
		// A start raised while busy is dropped; nothing follows the first pulse.
		u_cpu.issue(MSEC_REQ_JOG);
		u_cpu.issue(MSEC_REQ_POS);
		@(negedge clk_sys);
		chk("busy start", {11'h0, go_q | refuse_q | busy}, 12'h000);
		chk("busy kind", {9'h0, go_kind_q}, {9'h0, MSEC_REQ_JOG});
		$display("test jog done");
	endtask

	task automatic t_pos();
		{u_cpu.special_start, u_cpu.cond_no, u_cpu.pos_no} = {1'b1, 16'h0, 16'h0};
		run(MSEC_REQ_POS, 1'b0, ERR_COND_NO, 1'b1);
		u_cpu.cond_no = COND_MAX_DEF;
		run(MSEC_REQ_POS, 1'b0, ERR_POS_NO, 1'b1);
		{u_cpu.pos_no, u_cpu.special_start, u_cpu.cmd_speed} = {16'h1, 1'b0, 32'h0};
		run(MSEC_REQ_POS, 1'b0, ERR_NO_SPEED, 1'b1);
		{u_cpu.cmd_speed, u_cpu.is_linear} = {32'h0000_000A, 1'b1};
		u_cpu.lin_dist = LIN_MAX_DEF + 32'h1;
		run(MSEC_REQ_POS, 1'b0, ERR_LIN_RANGE, 1'b1);
		{u_cpu.is_linear, u_cpu.is_arc, u_cpu.arc_err} = {1'b0, 1'b1, 32'h0000_0006};
		run(MSEC_REQ_POS, 1'b0, ERR_ARC, 1'b1);
		u_cpu.arc_err = 32'h0000_0005;
		run(MSEC_REQ_POS, 1'b1, ERR_NONE, 1'b0);
		$display("test pos done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard, far beyond the fewer than one hundred cycles the tests need.
	initial begin
		#50000;
		n_fail++;
		complete_run();
	end

	// Reset for two cycles, then each scenario in turn.
	initial begin
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		chk("reset flag", {11'h0, err_flag_q}, 12'h000);
		chk("reset number", err_no_q, ERR_NONE);
		chk("reset busy", {11'h0, busy | go_q | refuse_q}, 12'h000);
		t_hr();
		t_jog();
		t_pos();
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
